/* File: src/mmh_regs.vh */
`ifndef MMH_REGS_VH
`define MMH_REGS_VH

// Word offsets on the register port
`define MMH_ADDR_W          6
`define MMH_REG_RSV_LAST    6'h1F
`define MMH_REG_DATA        6'h20
`define MMH_REG_SELECT      6'h21

// Target select fields
`define MMH_DEV_MSB         4
`define MMH_DEV_LSB         0
`define MMH_PRT_MSB         12
`define MMH_PRT_LSB         8
`define MMH_REG_MSB         31
`define MMH_REG_LSB         16

// Reset values
`define MMH_SELECT_RST      32'h0000_0000
`define MMH_DATA_RST        32'h0000_0000

// Frame field codes
`define MMH_ST_CODE         2'h0
`define MMH_OP_ADDR         2'h0
`define MMH_OP_WRITE        2'h1
`define MMH_OP_READ         2'h3
`define MMH_TA_DRIVE        2'h2

// Frame geometry in bit times
`define MMH_PRE_BITS        7'h20
`define MMH_FRAME_BITS      7'h40
`define MMH_DRIVE_BITS      7'h2E
`define MMH_SAMPLE_FIRST    7'h31

// Timing: bus clock and fastest allowed management clock
`define MMH_CLK_HZ          200000000
`define MMH_MDC_MAX_HZ      2500000
`define MMH_MDC_DIVISOR     ((`MMH_CLK_HZ + `MMH_MDC_MAX_HZ - 1) / `MMH_MDC_MAX_HZ)

`endif

/* File: src/mmh_mdc_gen.v */
`timescale 1ns/1ps
`default_nettype none
`include "mmh_regs.vh"

module mmh_mdc_gen #(
	parameter DIVISOR = `MMH_MDC_DIVISOR,
	parameter CNT_W   = 8
) (
	// Clock and reset
	input  wire clk,
	input  wire rst,
	// Management clock and its edge ticks
	output wire mdc,
	output wire rise_tick,
	output wire fall_tick
);

	// Full width terms, cut to the counter width on purpose
	localparam integer     HALF_I  = DIVISOR / 2 - 1;
	localparam integer     LAST_I  = DIVISOR - 1;
	localparam [CNT_W-1:0] HALF_M1 = HALF_I[CNT_W-1:0];
	localparam [CNT_W-1:0] LAST    = LAST_I[CNT_W-1:0];
	localparam [CNT_W-1:0] ONE     = 1;

	reg [CNT_W-1:0] cnt_q;
	reg             mdc_q;

	// Ticks mark the cycle at the end of which the clock pin toggles
	assign rise_tick = (cnt_q == HALF_M1);
	assign fall_tick = (cnt_q == LAST);
	assign mdc       = mdc_q;

	// Free running divider, low half then high half
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= {CNT_W{1'b0}};
			mdc_q <= 1'b0;
		end
		else
		begin
			if (fall_tick)
				cnt_q <= {CNT_W{1'b0}};
			else
				cnt_q <= cnt_q + ONE;
			if (rise_tick)
				mdc_q <= 1'b1;
			else if (fall_tick)
				mdc_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: src/mmh_host.v */
`timescale 1ns/1ps
`default_nettype none
`include "mmh_regs.vh"

// Contract
// - Access to word 0x20 launches a PHY write or read transfer.
// - Transfers use port, device, register held in word 0x21.
// - Word 0x21 bits 4:0 hold device address; 7:5 unused.
// - Word 0x21 bits 12:8 hold port address; 15:13 unused.
// - Word 0x21 bits 31:16 hold register address for address frame.
// - Words 0x00 to 0x1F are plain read/write storage.
// - 32-bit write and read data, word address, separate strobes.
// - Wait-request output holds off accesses not yet complete.
// - Reset clears the block asynchronously, except words 0x00 to 0x1F.
// - Data line split into in, out, active-low output enable.
// - Management clock divided from bus clock, at most 2.5 MHz.
// - Every frame starts with 32 one bits, then two zero bits.
// - Op codes 00 address, 01 write, 11 read; never 10.
// - Turnaround: drive 1,0 on address/write; release both on read.
// - Wait-request stays high until the management transfer ends.
module mmh_host #(
	parameter MDC_DIVISOR = `MMH_MDC_DIVISOR
) (
	// Clock and reset
	input  wire        CLK,
	input  wire        SYS_RST,
	// Register port
	input  wire        CSR_WRITE,
	input  wire        CSR_READ,
	input  wire [5:0]  CSR_ADDRESS,
	input  wire [31:0] CSR_WRITEDATA,
	output wire [31:0] CSR_READDATA,
	output wire        CSR_WAITREQUEST,
	// Management interface
	input  wire        MDIO_IN,
	output wire        MDIO_OUT,
	output wire        MDIO_OE_N,
	output wire        MDC
);

	// One-hot engine states
	localparam [2:0] S_IDLE = 3'h1;
	localparam [2:0] S_ADDR = 3'h2;
	localparam [2:0] S_DATA = 3'h4;

	localparam [6:0] BIT_ONE = 7'h01;

	// Reserved storage, no function attached
	reg [31:0] rsv_mem [0:31];

	// Register port state
	reg [31:0] select_q;
	reg [31:0] readdata_q;
	reg        ack_q;

	// Frame engine state
	reg [2:0]  state_q;
	reg [6:0]  bit_cnt_q;
	reg [31:0] shift_q;
	reg [15:0] rd_shift_q;
	reg [31:0] wdata_q;
	reg        is_read_q;
	reg        mdio_out_q;
	reg        mdio_oe_n_q;

	// Input synchroniser
	reg        din_meta_q;
	reg        din_q;

	wire       mdc_rise;
	wire       mdc_fall;
	wire       is_data_addr;
	wire       is_rsv_addr;
	wire       start;
	wire       frame_end;
	wire       frame_done;
	reg [31:0] rd_mux;

	// Word decode for the target select register; the read mux
	// and the write path must agree on it, so it lives in one place
	function sel_hit;
		input [5:0] addr;
		begin
			sel_hit = (addr == `MMH_REG_SELECT);
		end
	endfunction

	// Builds the 32 bits after the preamble, sent MSB first
	function [31:0] frame_word;
		input [1:0]  op;
		input [31:0] sel;
		input [15:0] payload;
		begin
			frame_word = {`MMH_ST_CODE, op,
				sel[`MMH_PRT_MSB:`MMH_PRT_LSB],
				sel[`MMH_DEV_MSB:`MMH_DEV_LSB],
				`MMH_TA_DRIVE, payload};
		end
	endfunction

	// Clock pin divider; it runs free so the engine only has to
	// wait for the next falling tick to begin a frame
	mmh_mdc_gen #(
		.DIVISOR   (MDC_DIVISOR),
		.CNT_W     (8)
	) u_mdc_gen (
		.clk       (CLK),
		.rst       (SYS_RST),
		.mdc       (MDC),
		.rise_tick (mdc_rise),
		.fall_tick (mdc_fall)
	);

	// Address decode on word offsets; a host with byte addresses
	// drops the two low bits before they reach this port, so the
	// decode below never needs to know about byte lanes
	assign is_data_addr = (CSR_ADDRESS == `MMH_REG_DATA);
	assign is_rsv_addr  = (CSR_ADDRESS <= `MMH_REG_RSV_LAST);

	// A data access starts once; the ack cycle must not restart it
	assign start = state_q[0] & is_data_addr & (CSR_READ | CSR_WRITE)
		& ~ack_q;
	assign frame_end  = mdc_fall & (bit_cnt_q == `MMH_FRAME_BITS);
	assign frame_done = state_q[2] & frame_end;

	// Every read waits one cycle so read data comes from a flop;
	// data accesses wait for the whole transfer.
	// Trade-off: a data access stalls the host for two full frames,
	// which at the slowest clock pin is thousands of bus cycles;
	// a host that cannot stall that long must avoid word 0x20
	// until it is ready to wait.
	assign CSR_WAITREQUEST = (CSR_READ | (CSR_WRITE & is_data_addr))
		& ~ack_q;
	assign CSR_READDATA = readdata_q;
	assign MDIO_OUT     = mdio_out_q;
	assign MDIO_OE_N    = mdio_oe_n_q;

	// Read data selection for the plain registers
	always @*
	begin
		rd_mux = 32'h0000_0000;
		if (is_rsv_addr)
			rd_mux = rsv_mem[CSR_ADDRESS[4:0]];
		else if (sel_hit(CSR_ADDRESS))
			rd_mux = select_q;
	end

	// Reserved words are storage only, so they carry no reset
	always @(posedge CLK)
	begin
		if (CSR_WRITE & is_rsv_addr)
			rsv_mem[CSR_ADDRESS[4:0]] <= CSR_WRITEDATA;
	end

	// Two flops before anything looks at the pin.
	// The line idles high through its pull-up, so the flops reset
	// high as well; the added delay is far below half a clock pin
	// period, so read bits are still taken well inside their window
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			din_meta_q <= 1'b1;
			din_q      <= 1'b1;
		end
		else
		begin
			din_meta_q <= MDIO_IN;
			din_q      <= din_meta_q;
		end
	end

	// Register port: select register, read data and acknowledge
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			select_q   <= `MMH_SELECT_RST;
			readdata_q <= 32'h0000_0000;
			ack_q      <= 1'b0;
		end
		else
		begin
			ack_q <= 1'b0;
			if (frame_done)
			begin
				ack_q <= 1'b1;
				// A write answer leaves the last read data in place
				if (is_read_q)
					readdata_q <= {16'h0000, rd_shift_q};
			end
			else if (CSR_READ & ~is_data_addr & ~ack_q)
			begin
				ack_q      <= 1'b1;
				readdata_q <= rd_mux;
			end
			// Unused bits stay writable and read back as written
			if (CSR_WRITE & ~CSR_READ
				& sel_hit(CSR_ADDRESS))
				select_q <= CSR_WRITEDATA;
		end
	end

	// Frame layout in bit times, counted by bit_cnt_q:
	//   0 to 31   preamble, all ones, line driven
	//   32, 33    start pattern, two zeros
	//   34, 35    operation code
	//   36 to 40  port address, MSB first
	//   41 to 45  device address, MSB first
	//   46, 47    turnaround
	//   48 to 63  register address or data, MSB first
	// Count 64 still holds bit 63 on the line; the falling tick
	// at that count releases the line and also ends the frame.
	// On a read frame the line is let go from bit 46 on, so the
	// far side may drive the second turnaround bit and the data
	// without a fight on the wire.
	// A read bit is taken at the rising tick after the bit has
	// been presented, which is half a clock pin period after the
	// far side moved it; the count is one ahead at that point,
	// hence the first sample at count 49.
	// The select register is read again for the second frame, so
	// a host must not rewrite it while a transfer is in flight;
	// the wait-request stall keeps a well behaved host from it.
	// Frame engine: bits change on the falling edge of the clock pin,
	// read bits are taken at its rising edge
	always @(posedge CLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			state_q     <= S_IDLE;
			bit_cnt_q   <= 7'h00;
			shift_q     <= 32'h0000_0000;
			rd_shift_q  <= 16'h0000;
			wdata_q     <= 32'h0000_0000;
			is_read_q   <= 1'b0;
			mdio_out_q  <= 1'b1;
			mdio_oe_n_q <= 1'b1;
		end
		else
		begin
			case (state_q)
			S_IDLE:
			begin
				if (start)
				begin
					is_read_q <= CSR_READ;
					wdata_q   <= CSR_WRITEDATA;
					bit_cnt_q <= 7'h00;
					shift_q   <= frame_word(`MMH_OP_ADDR, select_q,
						select_q[`MMH_REG_MSB:`MMH_REG_LSB]);
					state_q   <= S_ADDR;
				end
			end
			S_ADDR, S_DATA:
			begin
				if (frame_end)
				begin
					// Line released between frames and after the last
					mdio_out_q  <= 1'b1;
					mdio_oe_n_q <= 1'b1;
					bit_cnt_q   <= 7'h00;
					if (state_q[1])
					begin
						shift_q <= frame_word(is_read_q ? `MMH_OP_READ
							: `MMH_OP_WRITE, select_q,
							wdata_q[15:0]);
						state_q <= S_DATA;
					end
					else
						state_q <= S_IDLE;
				end
				else if (mdc_fall)
				begin
					bit_cnt_q <= bit_cnt_q + BIT_ONE;
					if (bit_cnt_q < `MMH_PRE_BITS)
					begin
						mdio_out_q  <= 1'b1;
						mdio_oe_n_q <= 1'b0;
					end
					else
					begin
						mdio_out_q  <= shift_q[31];
						shift_q     <= {shift_q[30:0], 1'b0};
						// Read frame lets go from turnaround onward
						mdio_oe_n_q <= state_q[2] & is_read_q
							& (bit_cnt_q >= `MMH_DRIVE_BITS);
					end
				end
				if (mdc_rise & state_q[2] & is_read_q
					& (bit_cnt_q >= `MMH_SAMPLE_FIRST))
					rd_shift_q <= {rd_shift_q[14:0], din_q};
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end

endmodule
`default_nettype wire

/* File: tb/mmh_host_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module mmh_host_checker #(
	parameter MDC_DIVISOR = 8
) (
	// Clock, reset and register port
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic        CSR_WRITE,
	input wire logic        CSR_READ,
	input wire logic [5:0]  CSR_ADDRESS,
	input wire logic [31:0] CSR_READDATA,
	input wire logic        CSR_WAITREQUEST,
	// Management pins
	input wire logic        MDIO_OUT,
	input wire logic        MDIO_OE_N,
	input wire logic        MDC
);
	localparam int HALF = MDC_DIVISOR / 2 - 1;
	logic [15:0] wait_q;
	logic [7:0]  half_q;
	logic        mdc_q;
	logic        seen_q;
	wire         a20 = (CSR_READ | CSR_WRITE) & (CSR_ADDRESS == 6'h20);
	wire         edg = MDC != mdc_q;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Counters; seen_q skips the odd first phase after reset
	always @(posedge CLK)
	begin
		mdc_q <= MDC;
		seen_q <= !SYS_RST & (seen_q | edg);
		half_q <= edg ? 8'h00 : half_q + 8'h01;
		wait_q <= (a20 & CSR_WAITREQUEST & !SYS_RST) ?
			wait_q + 16'h0001 : 16'h0000;
	end
	sequence s_ans;
		CSR_WAITREQUEST ##1 !CSR_WAITREQUEST;
	endsequence
	AST_RD_ANSWER: assert property (
		$rose(CSR_READ) && CSR_ADDRESS == 6'h21 |-> s_ans)
		else $error("register read answer late");
	AST_WR_NOWAIT: assert property (
		CSR_WRITE && CSR_ADDRESS != 6'h20 |-> !CSR_WAITREQUEST)
		else $error("plain write stalled");
	AST_XFER_WAIT: assert property (
		a20 && !CSR_WAITREQUEST |-> wait_q >= 128 * MDC_DIVISOR)
		else $error("data access ended before frames");
	AST_OE_IDLE: assert property (
		!a20 |-> MDIO_OE_N)
		else $error("line driven while idle");
	AST_BIT_STEADY: assert property (
		MDC && $past(MDC) |-> $stable(MDIO_OUT) && $stable(MDIO_OE_N))
		else $error("data line moved while clock high");
	AST_MDC_HALF: assert property (
		seen_q && edg |-> half_q == HALF)
		else $error("clock half period wrong");
	AST_RD_UPPER: assert property (
		a20 && CSR_READ && !CSR_WAITREQUEST |->
		CSR_READDATA[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	AST_RESET_IDLE: assert property (
		disable iff (1'b0) SYS_RST |-> MDIO_OE_N && !MDC)
		else $error("pins active in reset");
endmodule
bind mmh_host mmh_host_checker #(.MDC_DIVISOR(MDC_DIVISOR)) u_chk (.*);
`default_nettype wire

/* File: tb/mmh_phy_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mmh_phy_model (
	// Pins seen at the far side
	input wire logic    rst,
	input wire logic    mdc,
	input wire logic    line,
	input wire logic    oe_n,
	// Pull-down drive and captured frames
	output logic        drv,
	output logic        bit_o,
	output logic [33:0] frm,
	output int          n
);
	int          pos;
	int          ones;
	logic [31:0] sr;
	logic [1:0]  dt;
	logic [15:0] ra;
	logic        rd;
	initial
	begin
		drv = 0;
		ones = 0;
		n = 0;
		pos = 0;
	end
	// Sample on the rise; the station moves bits on the fall
	always @(posedge mdc or posedge rst)
	if (rst)
		pos = 0;
	else
	begin
		if (pos == 0 && !line && ones > 31)
			pos = 1;
		ones = line ? ones + 1 : 0;
		if (pos > 0)
		begin
			sr = {sr[30:0], line};
			if (pos == 15 || pos == 16)
				dt = {dt[0], !oe_n};
			if (pos == 4)
				rd = sr[1:0] == 2'b11;
			if (pos == 32)
			begin
				frm = {dt, sr};
				if (sr[29:28] == 2'b00)
					ra = sr[15:0];
				n++;
				pos = 0;
			end
			else
				pos++;
		end
	end
	// Answer reads with the inverted register address
	always @(negedge mdc or posedge rst)
	if (rst)
		drv = 0;
	else
	begin
		drv = rd && pos >= 16;
		bit_o = (pos == 16) ? 1'b0 : ~ra[32 - pos];
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 0;
	logic        rst = 0;
	logic        wr = 0;
	logic        rd = 0;
	logic [5:0]  ad = 0;
	logic [31:0] wd = 0;
	logic [31:0] sel;
	logic [31:0] v;
	wire [31:0]  rdat;
	wire         wt, mo, moe, mdc, pdrv, pbit;
	wire         line = (moe | mo) & (!pdrv | pbit);
	wire [33:0]  frm;
	int          nfr;
	int          miscompares = 0;
	int          n_tests = 0;
	logic [31:0] q_rd[$];
	logic [33:0] q_fr[$];
	mmh_host #(.MDC_DIVISOR(8)) DUT (.CLK(clk), .SYS_RST(rst),
		.CSR_WRITE(wr), .CSR_READ(rd), .CSR_ADDRESS(ad),
		.CSR_WRITEDATA(wd), .CSR_READDATA(rdat),
		.CSR_WAITREQUEST(wt), .MDIO_IN(line), .MDIO_OUT(mo),
		.MDIO_OE_N(moe), .MDC(mdc));
	mmh_phy_model PHY (.rst(rst), .mdc(mdc), .line(line), .oe_n(moe),
		.drv(pdrv), .bit_o(pbit), .frm(frm), .n(nfr));
	initial forever #2.5 clk = ~clk;
	task chk(input string nm, input logic [33:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s exp %h got %h", nm, exp, got);
		end
	endtask
	task end_sim;
		if (miscompares == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Register access held until the wait is lifted
	task acc(input logic w, input logic [5:0] a, input logic [31:0] d, e);
		if (!w)
			q_rd.push_back(e);
		@(negedge clk);
		wr = w;
		rd = !w;
		ad = a;
		wd = d;
		repeat (20000)
		begin
			#1;
			if (wt === 1'b0)
				break;
			@(negedge clk);
		end
		@(negedge clk);
		wr = 0;
		rd = 0;
	endtask
	// Address frame, then write or read frame
	task xfer(input logic w, input logic [31:0] s, d);
		logic [15:0] x;
		x = w ? d[15:0] : ~s[31:16];
		q_fr.push_back({4'hC, 2'b00, s[12:8], s[4:0], 2'b10, s[31:16]});
		q_fr.push_back({w ? 6'h31 : 6'h03, s[12:8], s[4:0], 2'b10, x});
		// Word 0x20 is byte 0x80 for a byte addressed host
		acc(w, 6'h20, d, {16'h0000, x});
	endtask
	// Watchers pop the oldest note as each result appears
	always @(negedge clk)
	begin
		#1;
		if (rd && wt === 1'b0)
			chk("readdata", rdat, q_rd.pop_front());
	end
	always @(nfr) chk("frame", frm, q_fr.pop_front());
	initial
	begin
		#200000;
		miscompares++;
		end_sim;
	end
	initial
	begin
		#1 rst = 1;
		void'($urandom(32'h3007));
		repeat (6) @(negedge clk);
		rst = 0;
		for (int i = 0; i < 4; i++)
		begin
			v = $urandom;
			acc(1, 6'(i * 10), v, 0);
			acc(0, 6'(i * 10), 0, v);
		end
		acc(0, 6'h3F, 0, 0);
		repeat (3)
		begin
			sel = $urandom;
			v = $urandom;
			acc(1, 6'h21, sel, 0);
			acc(0, 6'h21, 0, sel);
			xfer(1, sel, v);
			xfer(0, sel, v);
		end
		// Reset in mid-frame must act before any clock edge
		@(negedge clk);
		wr = 1;
		ad = 6'h20;
		repeat (300) @(negedge clk);
		rst = 1;
		wr = 0;
		#1 chk("oe_n", moe, 1);
		@(negedge clk);
		rst = 0;
		acc(0, 6'h21, 0, 0);
		end_sim;
	end
endmodule
`default_nettype wire
